// >>> bus_master_model.sv
// bus master model driving the receive line and decoding responses
`timescale 1ns/100ps
module bus_master_model #(
   parameter BIT_CLKS = 352
) (
   // clock
   input wire ref_clk_in,
   // serial line
   output reg line_out,
   input wire line_in,
   input wire line_oe_in
);
   reg [8:0] resp_q[$]; // fault flag above data
   reg [7:0] chk;
   reg [10:0] rbits;
   integer i;
   integer j;
   initial line_out = 1'b1;
   // one character: start, data lsb first, even parity, stop
   task send_char(input [7:0] d);
      reg [10:0] bits;
      begin
         bits = {1'b1, ^d, d, 1'b0};
         for (i = 0; i < 11; i = i + 1) begin
            line_out = bits[i];
            repeat (BIT_CLKS) @(negedge ref_clk_in);
         end
      end
   endtask
   // send and fold into the running check
   task put(input [7:0] b);
      begin
         chk = chk ^ b;
         send_char(b);
      end
   endtask
   // whole telegram, data high byte first
   task send_frame(input [7:0] adr, input [2:0] n, input [31:0] d);
      integer k;
      begin
         chk = 8'h00;
         put(8'h02);
         put(n + 8'h02);
         put(adr);
         for (k = n; k > 0; k = k - 1) put(d[8*k-1 -: 8]);
         send_char(chk);
      end
   endtask
   // decode characters while the follower drives
   initial forever begin
      @(negedge line_in);
      if (line_oe_in) begin
         repeat (BIT_CLKS / 2) @(posedge ref_clk_in);
         for (j = 0; j < 11; j = j + 1) begin
            rbits[j] = line_in;
            if (j < 10) repeat (BIT_CLKS) @(posedge ref_clk_in);
         end
         resp_q.push_back({rbits[0] | ~rbits[10] | (^rbits[9:1]), rbits[8:1]});
      end
   end
endmodule

// >>> serial_telegram_framer.v
// follower-side telegram framer for a multi-drop serial bus
// Function
// - start, eight data, parity, stop: eleven bits
// - data plus parity bits hold even ones
// - default even parity, one stop, configurable
// - baud selectable from 2400 to 115200
// - start char, length, address, data, check
// - length is data bytes plus two
// - text telegram length is ten plus text
// - bit7 clear: short address 1-31, bit6 ignored
// - short format bit5 set means broadcast
// - bit7 set: long address 1-126 in bits0-6
// - long format zero address means broadcast
// - response echoes received address byte unchanged
// - process, parameter, text types both directions
// - process block is two words
// - parameter block six words, process words last
// - check byte is xor from zero
// - identifier top nibble carries command/response code
`timescale 1ns/100ps
`include "telegram_framer_consts.vh"
module serial_telegram_framer #(
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW = 4
) (
   // clock and reset
   input wire ref_clk_in,
   input wire resetn_in,
   // serial line pins
   input wire rx_pin_in,
   output wire tx_pin_out,
   output wire tx_oe_out,
   // configuration
   input wire [6:0] node_addr_in,
   input wire [2:0] baud_sel_in,
   input wire parity_en_in,
   input wire parity_odd_in,
   input wire two_stop_in,
   // received telegram
   output reg [7:0] rx_byte_out,
   output reg rx_byte_valid_out,
   output reg [7:0] rx_byte_idx_out,
   output reg frame_ok_out,
   output reg frame_err_out,
   output reg broadcast_out,
   output reg [1:0] telegram_type_out,
   output reg [3:0] param_command_code_out,
   output reg [15:0] ctrl_word_out,
   output reg [15:0] ref_word_out,
   // response request
   input wire tx_start_in,
   input wire [7:0] resp_len_in,
   input wire [3:0] resp_code_in,
   output wire tx_busy_out,
   // response data stream
   input wire [7:0] tx_data_in,
   input wire tx_valid_in,
   output wire tx_ready_out
);
   // receiver character states
   localparam RS_IDLE = 3'h0;
   localparam RS_START = 3'h1;
   localparam RS_DATA = 3'h2;
   localparam RS_PAR = 3'h3;
   localparam RS_STOP = 3'h4;
   // receive telegram states
   localparam RF_IDLE = 3'h0;
   localparam RF_LEN = 3'h1;
   localparam RF_ADDR = 3'h2;
   localparam RF_DATA = 3'h3;
   // transmit telegram states
   localparam TF_IDLE = 3'h0;
   localparam TF_SOF = 3'h1;
   localparam TF_LEN = 3'h2;
   localparam TF_ADDR = 3'h3;
   localparam TF_DATA = 3'h4;
   localparam TF_CHK = 3'h5;
   localparam TF_DRAIN = 3'h6;

   // oversample divisor per baud choice, rounded to nearest
   function [11:0] baud_div;
      input [2:0] sel;
      reg [31:0] b;
      reg [31:0] q;
      begin
         case (sel)
            3'h0: b = `BAUD_2400;
            3'h1: b = `BAUD_4800;
            3'h2: b = `BAUD_9600;
            3'h3: b = `BAUD_19200;
            3'h4: b = `BAUD_38400;
            3'h5: b = `BAUD_57600;
            3'h6: b = `BAUD_76800;
            default: b = `BAUD_115200;
         endcase
         q = (`CLK_HZ + b * (`OVERSAMPLE / 2)) / (b * `OVERSAMPLE);
         baud_div = q[11:0];
      end
   endfunction

   reg [11:0] div_cnt_r;
   reg tick_r;
   reg rx_s1_r;
   reg rx_s2_r;
   reg [2:0] rs_st_r;
   reg [3:0] rs_ph_r;
   reg [2:0] rs_bit_r;
   reg [7:0] rs_sh_r;
   reg rs_perr_r;
   reg rs_done_r;
   reg rs_err_r;
   reg [2:0] rf_st_r;
   reg [7:0] rf_rem_r;
   reg [7:0] rf_len_r;
   reg [7:0] rf_chk_r;
   reg [7:0] rf_addr_r;
   reg [7:0] rf_idx_r;
   reg rf_match_r;
   reg rf_bcast_r;
   reg rf_bad_r;
   reg [3:0] rf_cmd_r;
   reg [31:0] rf_tail_r;
   reg [7:0] echo_addr_r;
   reg [2:0] tf_st_r;
   reg [7:0] tf_rem_r;
   reg [7:0] tf_len_r;
   reg [7:0] tf_chk_r;
   reg tf_first_r;
   reg [3:0] tf_code_r;
   reg [11:0] ts_sh_r;
   reg [3:0] ts_left_r;
   reg [3:0] ts_ph_r;
   reg tx_line_r;
   reg tx_oe_r;
   reg ts_load;
   reg [7:0] ts_byte;
   wire [7:0] fifo_data;
   wire fifo_valid;
   wire fifo_pop;
   wire ts_idle;
   wire [7:0] addr_b;
   wire addr_long;
   wire addr_bcast;
   wire addr_hit;
   wire [7:0] rf_chk_nxt;
   wire ts_par;

   // response data buffer; its ready is the fill-side back-pressure
   tx_byte_fifo #(
      .WIDTH(`DATA_BITS),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_tx_fifo (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .wr_data_in(tx_data_in),
      .wr_valid_in(tx_valid_in),
      .wr_ready_out(tx_ready_out),
      .rd_data_out(fifo_data),
      .rd_valid_out(fifo_valid),
      .rd_ready_in(fifo_pop)
   );

   // oversample enable from selected baud
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div_cnt_r <= 12'h000;
         tick_r <= 1'b0;
      end else if (div_cnt_r >= baud_div(baud_sel_in) - 12'h001) begin
         div_cnt_r <= 12'h000;
         tick_r <= 1'b1;
      end else begin
         div_cnt_r <= div_cnt_r + 12'h001;
         tick_r <= 1'b0;
      end
   end

   // receive pin synchroniser
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         rx_s1_r <= rx_pin_in;
         rx_s2_r <= rx_s1_r;
      end
   end

   // receive character engine, sampling mid-bit
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rs_st_r <= RS_IDLE;
         rs_ph_r <= 4'h0;
         rs_bit_r <= 3'h0;
         rs_sh_r <= 8'h00;
         rs_perr_r <= 1'b0;
         rs_done_r <= 1'b0;
         rs_err_r <= 1'b0;
      end else begin
         rs_done_r <= 1'b0;
         case (rs_st_r)
            RS_IDLE: begin
               rs_ph_r <= 4'h0;
               rs_perr_r <= 1'b0;
               if (!rx_s2_r) begin
                  rs_st_r <= RS_START;
               end
            end
            RS_START: begin
               if (tick_r) begin
                  rs_ph_r <= rs_ph_r + 4'h1;
                  if (rs_ph_r == `MID_START_PH) begin
                     rs_ph_r <= 4'h0;
                     rs_bit_r <= 3'h0;
                     rs_st_r <= rx_s2_r ? RS_IDLE : RS_DATA; // glitch rejected
                  end
               end
            end
            RS_DATA: begin
               if (tick_r) begin
                  rs_ph_r <= rs_ph_r + 4'h1;
                  if (rs_ph_r == `LAST_PH) begin
                     rs_sh_r <= {rx_s2_r, rs_sh_r[7:1]}; // lsb first
                     rs_bit_r <= rs_bit_r + 3'h1;
                     if (rs_bit_r == `LAST_DATA_BIT) begin
                        rs_st_r <= parity_en_in ? RS_PAR : RS_STOP;
                     end
                  end
               end
            end
            RS_PAR: begin
               if (tick_r) begin
                  rs_ph_r <= rs_ph_r + 4'h1;
                  if (rs_ph_r == `LAST_PH) begin
                     rs_perr_r <= (^{rs_sh_r, rx_s2_r}) ^ parity_odd_in;
                     rs_st_r <= RS_STOP;
                  end
               end
            end
            RS_STOP: begin
               if (tick_r) begin
                  rs_ph_r <= rs_ph_r + 4'h1;
                  if (rs_ph_r == `LAST_PH) begin
                     rs_err_r <= rs_perr_r | !rx_s2_r; // parity or framing
                     rs_done_r <= 1'b1;
                     rs_st_r <= RS_IDLE;
                  end
               end
            end
            default: rs_st_r <= RS_IDLE;
         endcase
      end
   end

   // address decode of the byte just received
   assign addr_b = rs_sh_r;
   assign addr_long = addr_b[`ADDR_LONG_BIT];
   assign addr_bcast = addr_long ? (addr_b[6:0] == 7'h00) : addr_b[`ADDR_BCAST_BIT];
   assign addr_hit = addr_long ? (addr_b[6:0] == node_addr_in) :
      (node_addr_in <= `ADDR_SHORT_MAX && addr_b[4:0] == node_addr_in[4:0]); // bit6 ignored
   assign rf_chk_nxt = rf_chk_r ^ rs_sh_r;

   // receive telegram framing and filtering
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rf_st_r <= RF_IDLE;
         rf_rem_r <= 8'h00;
         rf_len_r <= 8'h00;
         rf_chk_r <= 8'h00;
         rf_addr_r <= 8'h00;
         rf_idx_r <= 8'h00;
         rf_match_r <= 1'b0;
         rf_bcast_r <= 1'b0;
         rf_bad_r <= 1'b0;
         rf_cmd_r <= 4'h0;
         rf_tail_r <= 32'h0000_0000;
         echo_addr_r <= 8'h00;
         rx_byte_out <= 8'h00;
         rx_byte_valid_out <= 1'b0;
         rx_byte_idx_out <= 8'h00;
         frame_ok_out <= 1'b0;
         frame_err_out <= 1'b0;
         broadcast_out <= 1'b0;
         telegram_type_out <= `TYPE_PROCESS;
         param_command_code_out <= 4'h0;
         ctrl_word_out <= 16'h0000;
         ref_word_out <= 16'h0000;
      end else begin
         rx_byte_valid_out <= 1'b0;
         frame_ok_out <= 1'b0;
         frame_err_out <= 1'b0;
         if (rs_done_r) begin
            case (rf_st_r)
               RF_IDLE: begin
                  if (!rs_err_r && rs_sh_r == `SOF_CHAR) begin
                     rf_chk_r <= rs_sh_r; // accumulator starts at zero
                     rf_bad_r <= 1'b0;
                     rf_st_r <= RF_LEN;
                  end
               end
               RF_LEN: begin
                  rf_chk_r <= rf_chk_nxt;
                  rf_len_r <= rs_sh_r;
                  rf_rem_r <= rs_sh_r - 8'h01; // address excluded
                  rf_bad_r <= rf_bad_r | rs_err_r;
                  rf_st_r <= (rs_sh_r < `LEN_OVERHEAD) ? RF_IDLE : RF_ADDR;
               end
               RF_ADDR: begin
                  rf_chk_r <= rf_chk_nxt;
                  rf_addr_r <= rs_sh_r;
                  rf_match_r <= addr_hit | addr_bcast;
                  rf_bcast_r <= addr_bcast;
                  rf_idx_r <= 8'h00;
                  rf_bad_r <= rf_bad_r | rs_err_r;
                  rf_st_r <= RF_DATA;
               end
               RF_DATA: begin
                  rf_chk_r <= rf_chk_nxt;
                  rf_rem_r <= rf_rem_r - 8'h01;
                  rf_bad_r <= rf_bad_r | rs_err_r;
                  if (rf_rem_r == 8'h01) begin
                     // check byte closes the telegram
                     rf_st_r <= RF_IDLE;
                     if (rf_match_r) begin // others dropped silently
                        if (!rf_bad_r && !rs_err_r && rf_chk_nxt == 8'h00) begin
                           frame_ok_out <= 1'b1;
                           broadcast_out <= rf_bcast_r;
                           echo_addr_r <= rf_addr_r; // kept unchanged
                           param_command_code_out <= rf_cmd_r;
                           ctrl_word_out <= rf_tail_r[31:16];
                           ref_word_out <= rf_tail_r[15:0];
                           if (rf_len_r == `LEN_PROCESS) begin
                              telegram_type_out <= `TYPE_PROCESS;
                           end else if (rf_len_r == `LEN_PARAM) begin
                              telegram_type_out <= `TYPE_PARAM;
                           end else if (rf_len_r >= `LEN_TEXT_FIXED) begin
                              telegram_type_out <= `TYPE_TEXT;
                           end else begin
                              telegram_type_out <= `TYPE_OTHER;
                           end
                        end else begin
                           frame_err_out <= 1'b1;
                        end
                     end
                  end else begin
                     rf_idx_r <= rf_idx_r + 8'h01;
                     rf_tail_r <= {rf_tail_r[23:0], rs_sh_r}; // last four bytes
                     if (rf_idx_r == 8'h00) begin
                        rf_cmd_r <= rs_sh_r[7:4];
                     end
                     if (rf_match_r) begin
                        rx_byte_out <= rs_sh_r;
                        rx_byte_idx_out <= rf_idx_r;
                        rx_byte_valid_out <= 1'b1;
                     end
                  end
               end
               default: rf_st_r <= RF_IDLE;
            endcase
         end
      end
   end

   // transmit byte selection for the serializer
   assign ts_idle = (ts_left_r == 4'h0);
   assign fifo_pop = ts_idle && tf_st_r == TF_DATA && fifo_valid;
   always @* begin
      ts_load = 1'b0;
      ts_byte = 8'h00;
      if (ts_idle) begin
         case (tf_st_r)
            TF_SOF: begin
               ts_load = 1'b1;
               ts_byte = `SOF_CHAR;
            end
            TF_LEN: begin
               ts_load = 1'b1;
               ts_byte = tf_len_r;
            end
            TF_ADDR: begin
               ts_load = 1'b1;
               ts_byte = echo_addr_r;
            end
            TF_DATA: begin
               ts_load = fifo_valid;
               ts_byte = fifo_data;
               if (tf_first_r && tf_len_r != `LEN_PROCESS) begin
                  ts_byte = {tf_code_r, fifo_data[3:0]}; // response code
               end
            end
            TF_CHK: begin
               ts_load = 1'b1;
               ts_byte = tf_chk_r;
            end
            default: ts_load = 1'b0;
         endcase
      end
   end

   // transmit telegram sequencing
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tf_st_r <= TF_IDLE;
         tf_rem_r <= 8'h00;
         tf_len_r <= 8'h00;
         tf_chk_r <= 8'h00;
         tf_first_r <= 1'b0;
         tf_code_r <= 4'h0;
      end else begin
         if (ts_load) begin
            tf_chk_r <= tf_chk_r ^ ts_byte;
         end
         case (tf_st_r)
            TF_IDLE: begin
               if (tx_start_in) begin
                  tf_len_r <= resp_len_in + `LEN_OVERHEAD;
                  tf_rem_r <= resp_len_in;
                  tf_code_r <= resp_code_in;
                  tf_chk_r <= 8'h00;
                  tf_first_r <= 1'b1;
                  tf_st_r <= TF_SOF;
               end
            end
            TF_SOF: if (ts_load) tf_st_r <= TF_LEN;
            TF_LEN: if (ts_load) tf_st_r <= TF_ADDR;
            TF_ADDR: if (ts_load) tf_st_r <= (tf_rem_r == 8'h00) ? TF_CHK : TF_DATA;
            TF_DATA: begin
               if (ts_load) begin
                  tf_first_r <= 1'b0;
                  tf_rem_r <= tf_rem_r - 8'h01;
                  if (tf_rem_r == 8'h01) begin
                     tf_st_r <= TF_CHK;
                  end
               end
            end
            TF_CHK: if (ts_load) tf_st_r <= TF_DRAIN;
            TF_DRAIN: if (ts_idle) tf_st_r <= TF_IDLE;
            default: tf_st_r <= TF_IDLE;
         endcase
      end
   end

   // parity over data byte, even unless odd chosen
   assign ts_par = (^ts_byte) ^ parity_odd_in;

   // transmit character serializer, lsb first
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ts_sh_r <= 12'hFFF;
         ts_left_r <= 4'h0;
         ts_ph_r <= 4'h0;
         tx_line_r <= 1'b1;
         tx_oe_r <= 1'b0;
      end else begin
         tx_oe_r <= (tf_st_r != TF_IDLE);
         if (ts_load) begin
            // start, data, optional parity, one or two stops
            if (parity_en_in) begin
               ts_sh_r <= {2'h3, ts_par, ts_byte, 1'b0};
            end else begin
               ts_sh_r <= {3'h7, ts_byte, 1'b0};
            end
            ts_left_r <= `CHAR_BITS_MIN + {3'h0, parity_en_in} + {3'h0, two_stop_in};
            ts_ph_r <= 4'h0;
         end else if (!ts_idle && tick_r) begin
            ts_ph_r <= ts_ph_r + 4'h1;
            if (ts_ph_r == 4'h0) begin
               tx_line_r <= ts_sh_r[0];
               ts_sh_r <= {1'b1, ts_sh_r[11:1]};
            end
            if (ts_ph_r == `LAST_PH) begin
               ts_left_r <= ts_left_r - 4'h1;
            end
         end else if (ts_idle) begin
            tx_line_r <= 1'b1;
         end
      end
   end

   assign tx_pin_out = tx_line_r;
   assign tx_oe_out = tx_oe_r;
   assign tx_busy_out = (tf_st_r != TF_IDLE);
endmodule

// >>> serial_telegram_framer_asserts.sv
// concurrent checks on the telegram framer ports
`timescale 1ns/100ps
module framer_checker (
   // clock and reset
   input wire ref_clk_in,
   input wire resetn_in,
   // watched ports
   input wire tx_pin_out,
   input wire tx_oe_out,
   input wire tx_busy_out,
   input wire tx_start_in,
   input wire rx_byte_valid_out,
   input wire frame_ok_out,
   input wire frame_err_out,
   input wire broadcast_out,
   input wire [1:0] telegram_type_out,
   input wire [15:0] ctrl_word_out,
   input wire [15:0] ref_word_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   // accepted launch, then busy, then driver enable
   sequence s_launch;
      tx_start_in && !tx_busy_out;
   endsequence
   sequence s_drive;
      tx_busy_out && !tx_oe_out ##1 tx_oe_out;
   endsequence
   chk_oe_launch: assert property (s_launch |=> s_drive) else $error("driver enable late");
   chk_idle_high: assert property (!tx_oe_out |-> tx_pin_out) else $error("line not idle high");
   chk_oe_follows: assert property (tx_oe_out |-> $past(tx_busy_out)) else $error("enable without busy");
   chk_pulse_excl: assert property (!(frame_ok_out && frame_err_out)) else $error("ok and error together");
   chk_ok_single: assert property (frame_ok_out |=> !frame_ok_out && !rx_byte_valid_out)
      else $error("frame ok not single");
   chk_valid_gap: assert property (rx_byte_valid_out |=> !rx_byte_valid_out[*8])
      else $error("data bytes too close");
   chk_words_hold: assert property ($changed({ctrl_word_out, ref_word_out}) |-> frame_ok_out || $past(frame_ok_out))
      else $error("words changed without frame");
   chk_status_hold: assert property ($changed({broadcast_out, telegram_type_out}) |-> frame_ok_out || $past(frame_ok_out))
      else $error("status changed without frame");
endmodule
bind serial_telegram_framer framer_checker framer_checker_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
   .tx_pin_out(tx_pin_out), .tx_oe_out(tx_oe_out), .tx_busy_out(tx_busy_out), .tx_start_in(tx_start_in),
   .rx_byte_valid_out(rx_byte_valid_out), .frame_ok_out(frame_ok_out), .frame_err_out(frame_err_out),
   .broadcast_out(broadcast_out), .telegram_type_out(telegram_type_out), .ctrl_word_out(ctrl_word_out),
   .ref_word_out(ref_word_out));

// >>> serial_telegram_framer_bench.sv
// self-checking bench for the telegram framer
`timescale 1ns/100ps
module serial_telegram_framer_bench;
   reg ref_clk_in = 1'b0;
   reg resetn_in = 1'b0;
   reg tx_start_in = 1'b0;
   reg [7:0] resp_len_in = 8'h00;
   reg [3:0] resp_code_in = 4'h2;
   reg [7:0] tx_data_in = 8'h00;
   reg tx_valid_in = 1'b0;
   wire rx_pin_in, tx_pin_out, tx_oe_out, rx_byte_valid_out, frame_ok_out, frame_err_out;
   wire broadcast_out, tx_busy_out, tx_ready_out;
   wire [7:0] rx_byte_out, rx_byte_idx_out;
   wire [1:0] telegram_type_out;
   wire [3:0] param_command_code_out;
   wire [15:0] ctrl_word_out, ref_word_out;
   integer err_total = 0;
   integer checks = 0;
   integer oks = 0;
   integer errs = 0;
   integer r, n;
   reg [7:0] got [0:3];
   reg [8:0] rows [0:2]; // address byte, expected broadcast
   reg [44:0] exp_resp;
   // 40 MHz clock
   always #12.5 ref_clk_in = ~ref_clk_in;
   serial_telegram_framer serial_telegram_framer_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .rx_pin_in(rx_pin_in), .tx_pin_out(tx_pin_out), .tx_oe_out(tx_oe_out), .node_addr_in(7'h05),
      .baud_sel_in(3'h7), .parity_en_in(1'b1), .parity_odd_in(1'b0), .two_stop_in(1'b0),
      .rx_byte_out(rx_byte_out), .rx_byte_valid_out(rx_byte_valid_out), .rx_byte_idx_out(rx_byte_idx_out),
      .frame_ok_out(frame_ok_out), .frame_err_out(frame_err_out), .broadcast_out(broadcast_out),
      .telegram_type_out(telegram_type_out), .param_command_code_out(param_command_code_out),
      .ctrl_word_out(ctrl_word_out), .ref_word_out(ref_word_out), .tx_start_in(tx_start_in),
      .resp_len_in(resp_len_in), .resp_code_in(resp_code_in), .tx_busy_out(tx_busy_out), .tx_data_in(tx_data_in),
      .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out));
   bus_master_model bus_master_model_inst (.ref_clk_in(ref_clk_in), .line_out(rx_pin_in),
      .line_in(tx_pin_out), .line_oe_in(tx_oe_out));
   // count good frames and keep data bytes
   always @(negedge ref_clk_in) begin
      if (frame_ok_out === 1'b1) oks = oks + 1;
      if (frame_err_out === 1'b1) errs = errs + 1;
      if (rx_byte_valid_out === 1'b1) got[rx_byte_idx_out[1:0]] = rx_byte_out;
   end
   // compare one value
   task cmp_val(input string what, input [35:0] exp, input [35:0] seen);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
         end
      end
   endtask
   // verdict and end of run
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", checks, err_total);
         if (err_total == 0 && checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   // watchdog
   initial begin
      #2500000;
      err_total = err_total + 1;
      complete_run;
   end
   // main sequence
   initial begin
      rows[0] = {8'h25, 1'b1};
      rows[1] = {8'h80, 1'b1};
      rows[2] = {8'h85, 1'b0};
      repeat (3) @(negedge ref_clk_in);
      cmp_val("reset line", 3'h5, {tx_pin_out, tx_oe_out, tx_ready_out});
      resetn_in = 1'b1;
      repeat (400) @(negedge ref_clk_in);
      // short telegrams to broadcast and own long address
      for (r = 0; r < 3; r = r + 1) begin
         n = oks;
         bus_master_model_inst.send_frame(rows[r][8:1], 3'h0, 32'h0);
         repeat (40) @(negedge ref_clk_in);
         cmp_val("frame ok count", n + 1, oks);
         cmp_val("broadcast", rows[r][0], broadcast_out);
         cmp_val("type", 2'h3, telegram_type_out);
      end
      // process telegram, short address with bit 6 set
      n = oks;
      bus_master_model_inst.send_frame(8'h45, 3'h4, 32'hF234A678);
      repeat (40) @(negedge ref_clk_in);
      cmp_val("frame ok count", n + 1, oks);
      cmp_val("data bytes", 32'hF234A678, {got[0], got[1], got[2], got[3]});
      cmp_val("words", 32'hF234A678, {ctrl_word_out, ref_word_out});
      cmp_val("type", 2'h0, telegram_type_out);
      cmp_val("command", 4'hF, param_command_code_out);
      cmp_val("frame errors", 0, errs);
      // one-byte response with code, a second start while busy
      resp_len_in = 8'h01;
      tx_data_in = 8'h3C;
      tx_valid_in = 1'b1;
      tx_start_in = 1'b1;
      @(negedge ref_clk_in);
      tx_valid_in = 1'b0;
      tx_start_in = 1'b0;
      repeat (100) @(negedge ref_clk_in);
      tx_start_in = 1'b1;
      @(negedge ref_clk_in);
      tx_start_in = 1'b0;
      for (r = 0; r < 20000 && tx_busy_out !== 1'b0; r = r + 1) @(negedge ref_clk_in);
      repeat (400) @(negedge ref_clk_in);
      cmp_val("idle after response", 1'b0, tx_busy_out);
      cmp_val("response chars", 5, bus_master_model_inst.resp_q.size());
      exp_resp = {9'h002, 9'h003, 9'h045, 9'h02C, 9'h068};
      for (r = 0; r < 5; r = r + 1) begin
         cmp_val("response char", exp_resp[44-9*r -: 9], bus_master_model_inst.resp_q.pop_front());
      end
      // fill the transmit buffer until it refuses
      tx_valid_in = 1'b1;
      for (r = 0; r < 16; r = r + 1) begin
         tx_data_in = r[7:0];
         @(negedge ref_clk_in);
      end
      tx_valid_in = 1'b0;
      cmp_val("buffer full", 1'b0, tx_ready_out);
      // reset in mid-run clears buffer and status
      resetn_in = 1'b0;
      @(negedge ref_clk_in);
      cmp_val("reset state", 34'h200000000, {tx_ready_out, broadcast_out, ctrl_word_out, ref_word_out});
      resetn_in = 1'b1;
      complete_run;
   end
endmodule

// >>> telegram_framer_consts.vh
// constants for the serial telegram framer
`ifndef TELEGRAM_FRAMER_CONSTS_VH
`define TELEGRAM_FRAMER_CONSTS_VH
// clock and bit timing
`define CLK_HZ 40000000
`define OVERSAMPLE 16
`define MID_START_PH 4'h7
`define LAST_PH 4'hF
`define BAUD_2400 2400
`define BAUD_4800 4800
`define BAUD_9600 9600
`define BAUD_19200 19200
`define BAUD_38400 38400
`define BAUD_57600 57600
`define BAUD_76800 76800
`define BAUD_115200 115200
// character layout
`define DATA_BITS 8
`define CHAR_BITS_MIN 4'hA
`define LAST_DATA_BIT 3'h7
// telegram layout
`define SOF_CHAR 8'h02
`define LEN_OVERHEAD 8'h02
`define LEN_PROCESS 8'h06
`define LEN_PARAM 8'h0E
`define LEN_TEXT_FIXED 8'h0A
`define PROC_BYTES 8'h04
`define ADDR_LONG_BIT 7
`define ADDR_BCAST_BIT 5
`define ADDR_SHORT_MAX 7'h1F
// telegram type codes
`define TYPE_PROCESS 2'h0
`define TYPE_PARAM 2'h1
`define TYPE_TEXT 2'h2
`define TYPE_OTHER 2'h3
// reset values
`define PARITY_EVEN 1'b0
`endif

// >>> tx_byte_fifo.v
// synchronous fifo holding response data bytes
`timescale 1ns/100ps
module tx_byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // clock and reset
   input wire ref_clk_in,
   input wire resetn_in,
   // fill side
   input wire [WIDTH-1:0] wr_data_in,
   input wire wr_valid_in,
   output wire wr_ready_out,
   // drain side
   output wire [WIDTH-1:0] rd_data_out,
   output wire rd_valid_out,
   input wire rd_ready_in
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   wire push;
   wire pop;

   // honest full and empty from occupancy
   assign wr_ready_out = (count_r != DEPTH[AW:0]);
   assign rd_valid_out = (count_r != {(AW+1){1'b0}});
   assign rd_data_out = mem[rd_ptr_r];
   assign push = wr_valid_in & wr_ready_out;
   assign pop = rd_valid_out & rd_ready_in;

   // storage array, no reset needed
   always @(posedge ref_clk_in) begin
      if (push) begin
         mem[wr_ptr_r] <= wr_data_in;
      end
   end

   // pointers and occupancy
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         if (push & !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop & !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule
